//--- core/modbus_cmd.sv
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "mb_params.svh"
// Contract
// [R1] read request: addr fn table offset count crc
// [R2] read reply: addr fn 2N data crc
// [R3] broadcast read and loop-back ignored
// [R4] single write, then echo request
// [R5] broadcast writes executed, never answered
// [R6] single write zeroes upper half of long
// [R7] loop-back sub-code zero echoes frame
// [R8] multi write request layout with 2N bytes
// [R9] multi write reply: header six bytes, crc
// [R10] long values msb first, count twice
// [R11] host matches data width to table
// [R12] crc failure: discard, no reply
// [R13] serviceable errors give exception reply
// [R14] exception function code has msb set
// [R15] exception reply is five bytes
// [R16] exception codes one to four
// [R17] invalid value gives exception five
// [R18] locked comms writes give exception six
// [R19] own-address frame lights addressed indicator
// [R20] addressed crc error or exception lights fault
// [R21] receive pin transitions light toggle indicator
// [R22] meter link steady on, flashes when busy
// [R23] crc-16 preset ones, poly a001 reflected
// [R24] register address is table then offset
// [R25] host writes 123 to access first
// [R26] frame ends after 3.5 character idle gap; code waits a fixed GAP_US of 4010 us at any baud_rate
// [R27] foreign address frames silently ignored
module modbus_cmd #(
	parameter int DEPTH = 64,
	parameter int GAP_CYCLES = `GAP_US * (`CLK_HZ / 1000000),
	parameter int HOLD_CYCLES = `HOLD_MS * (`CLK_HZ / 1000),
	parameter logic [7:0] DEF_ADDR = 8'h01,
	parameter logic [15:0] DEF_BAUD = `BAUD_96
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// received bytes and raw line
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic rx_pin,
	// transmit bytes
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	// meter data tables
	output logic [15:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic meter_busy,
	// comms setup
	output logic [7:0] slave_addr,
	output logic [15:0] baud_rate,
	// indicators
	output logic addr_frame_ind,
	output logic fault_ind,
	output logic line_toggle_indicator,
	output logic meter_link_ind
);
	localparam int AW = $clog2(DEPTH);
	// a macro literal cannot be bit-selected, so the header length lives here as a typed constant
	localparam logic [15:0] RD_HDR_W = `RD_HDR;

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1); // [R23]
		end
		return r;
	endfunction

	function automatic logic [7:0] tbl_size(input logic [7:0] t);
		case (t)
			`TBL_INST: tbl_size = `SZ_INST;
			`TBL_ENERGY: tbl_size = `SZ_ENERGY;
			`TBL_SETUP: tbl_size = `SZ_SETUP;
			`TBL_DESC: tbl_size = `SZ_DESC;
			`TBL_COMMS: tbl_size = `SZ_COMMS;
			default: tbl_size = 8'h00;
		endcase
	endfunction

	logic [7:0] buf_r [DEPTH];
	logic [15:0] len_r, crc_rx_r, crc_tx_r, access_r, baud_r;
	logic ovf_r, rx_pin_r, word_ok_r, tx_valid_r, mem_rd_r, mem_wr_r;
	logic [31:0] gap_r, word_r, mem_wdata_r;
	logic [7:0] slave_r, exc_r, tx_data_r, ent_r;
	logic [15:0] idx_r, total_r, wr_idx_r, ptr_r, mem_addr_r;
	mb_pkg::state_t st_r;
	mb_pkg::kind_t kind_r;

	// decode of the held frame
	logic [7:0] fn, tbl, off, size, dec_exc, tx_byte, rd_ent;
	logic [15:0] nw, ent, k;
	logic is_long, is_rw, own, bc, crc_ok, range_ok, dec_ignore, need_fetch;
	assign fn = buf_r[1];
	assign tbl = buf_r[2];
	assign off = buf_r[3];
	assign nw = {buf_r[4], buf_r[5]};
	assign size = tbl_size(tbl);
	assign is_long = (tbl == `TBL_ENERGY); // [R10]
	assign is_rw = (tbl == `TBL_ENERGY) || (tbl == `TBL_SETUP) || (tbl == `TBL_COMMS);
	assign ent = is_long ? (nw >> 1) : nw;
	assign own = (buf_r[0] == slave_r);
	assign bc = (buf_r[0] == `BCAST);
	assign crc_ok = (crc_rx_r == 16'h0000) && (len_r >= `MIN_LEN) && !ovf_r; // [R12] [R23]
	assign range_ok = (size != 8'h00) && (nw != 16'h0000) && !(is_long && nw[0]) &&
		(({8'h00, off} + ent) <= {8'h00, size});

	always_comb begin
		dec_ignore = 1'b1;
		dec_exc = 8'h00;
		if ((own || bc) && crc_ok) begin // [R27] [R12]
			dec_ignore = 1'b0;
			case (fn)
				`FN_RD_HOLD, `FN_RD_IN: begin
					if (bc || len_r != `REQ_LEN) // [R3] [R1]
						dec_ignore = 1'b1;
					else if (nw > `RD_MAX)
						dec_exc = `EXC_BIG; // [R16]
					else if (!range_ok)
						dec_exc = `EXC_RANGE; // [R16]
				end
				`FN_WR1: begin
					if (len_r != `REQ_LEN)
						dec_ignore = 1'b1;
					else if (size == 8'h00 || !is_rw || off >= size)
						dec_exc = `EXC_RANGE; // [R16]
				end
				`FN_LOOP: begin
					if (bc || len_r != `REQ_LEN) // [R3]
						dec_ignore = 1'b1;
					else if ({buf_r[2], buf_r[3]} != 16'h0000)
						dec_exc = `EXC_FUNC; // [R7]
				end
				`FN_WRN: begin
					if (!range_ok || !is_rw)
						dec_exc = `EXC_RANGE;
					else if ({8'h00, buf_r[`P_BCNT]} != (nw << 1) || len_r != `WRN_LEN + (nw << 1))
						dec_exc = `EXC_BIG; // [R8]
				end
				default: dec_exc = `EXC_FUNC; // [R16]
			endcase
		end
	end

	// value checks for the comms setup table
	function automatic logic [7:0] comms_chk(input logic [7:0] o, input logic [15:0] v, input logic unl);
		comms_chk = 8'h00;
		case (o)
			`OFF_ACCESS: if (v > `ACCESS_MAX) comms_chk = `EXC_BIG;
			`OFF_ADDR: begin
				if (!unl)
					comms_chk = `EXC_LOCK; // [R18]
				else if (v == 16'h0000)
					comms_chk = `EXC_SMALL; // [R16]
				else if (v > `ADDR_MAX)
					comms_chk = `EXC_BIG;
			end
			default: begin
				if (!unl)
					comms_chk = `EXC_LOCK; // [R18]
				else if (v != `BAUD_48 && v != `BAUD_96 && v != `BAUD_192)
					comms_chk = `EXC_VALUE; // [R17]
			end
		endcase
	endfunction

	// entry and value for the write loop
	logic [7:0] wr_ent, wr_code;
	logic [31:0] wr_val;
	logic wr_wide;
	assign wr_ent = off + wr_idx_r[7:0];
	assign wr_wide = is_long && (fn == `FN_WRN);
	assign wr_val = wr_wide ? {buf_r[ptr_r[AW-1:0]], buf_r[ptr_r[AW-1:0] + 1'b1],
		buf_r[ptr_r[AW-1:0] + 2'h2], buf_r[ptr_r[AW-1:0] + 2'h3]} :
		{16'h0000, buf_r[ptr_r[AW-1:0]], buf_r[ptr_r[AW-1:0] + 1'b1]}; // [R6] [R10]
	assign wr_code = comms_chk(wr_ent, wr_val[15:0], access_r == `UNLOCK_KEY);

	// outgoing byte selection
	assign k = (idx_r - `RD_HDR) >> 1;
	assign rd_ent = off + (is_long ? k[8:1] : k[7:0]);
	assign need_fetch = (kind_r == mb_pkg::K_READ) && idx_r >= `RD_HDR && idx_r < total_r &&
		!(idx_r[0] ^ RD_HDR_W[0]) && !word_ok_r;
	always_comb begin
		logic [15:0] w;
		w = (is_long && !k[0]) ? word_r[31:16] : word_r[15:0];
		tx_byte = buf_r[idx_r[AW-1:0]];
		if (idx_r == total_r)
			tx_byte = crc_tx_r[7:0];
		else if (idx_r > total_r)
			tx_byte = crc_tx_r[15:8];
		else if (kind_r == mb_pkg::K_EXC && idx_r == 16'h0001)
			tx_byte = fn | `EXC_FLAG; // [R14]
		else if (kind_r == mb_pkg::K_EXC && idx_r == 16'h0002)
			tx_byte = exc_r;
		else if (kind_r == mb_pkg::K_READ && idx_r == 16'h0002)
			tx_byte = {nw[6:0], 1'b0}; // [R2]
		else if (kind_r == mb_pkg::K_READ && idx_r >= `RD_HDR)
			tx_byte = (idx_r[0] ^ RD_HDR_W[0]) ? w[7:0] : w[15:8]; // [R2]
	end

	// frame collection; bytes arriving while busy are dropped (half duplex)
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			len_r <= 16'h0000;
			ovf_r <= 1'b0;
			crc_rx_r <= `CRC_INIT;
		end else if (st_r == mb_pkg::S_CHECK) begin
			len_r <= 16'h0000;
			ovf_r <= 1'b0;
			crc_rx_r <= `CRC_INIT;
		end else if (st_r == mb_pkg::S_IDLE && rx_valid) begin
			if (len_r < 16'(DEPTH)) begin
				buf_r[len_r[AW-1:0]] <= rx_data;
				len_r <= len_r + 16'h0001;
			end else
				ovf_r <= 1'b1;
			crc_rx_r <= crc_byte(crc_rx_r, rx_data); // [R23]
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || rx_valid)
			gap_r <= 32'h0;
		else if (gap_r < 32'(GAP_CYCLES))
			gap_r <= gap_r + 32'h1; // [R26]
	end

	// command sequencer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= mb_pkg::S_IDLE;
			kind_r <= mb_pkg::K_ECHO;
			exc_r <= 8'h00;
			idx_r <= 16'h0000;
			total_r <= 16'h0000;
			wr_idx_r <= 16'h0000;
			ptr_r <= 16'h0000;
			ent_r <= 8'h00;
			word_r <= 32'h0;
			word_ok_r <= 1'b0;
			tx_valid_r <= 1'b0;
			tx_data_r <= 8'h00;
			crc_tx_r <= `CRC_INIT;
			mem_rd_r <= 1'b0;
			mem_wr_r <= 1'b0;
			mem_addr_r <= 16'h0000;
			mem_wdata_r <= 32'h0;
			access_r <= 16'h0000;
			slave_r <= DEF_ADDR;
			baud_r <= DEF_BAUD;
		end else begin
			mem_wr_r <= 1'b0;
			case (st_r)
				mb_pkg::S_IDLE: begin
					if (len_r != 16'h0000 && gap_r == 32'(GAP_CYCLES - 1))
						st_r <= mb_pkg::S_CHECK; // [R26]
				end
				mb_pkg::S_CHECK: begin
					idx_r <= 16'h0000;
					crc_tx_r <= `CRC_INIT;
					word_ok_r <= 1'b0;
					exc_r <= dec_exc;
					if (dec_ignore)
						st_r <= mb_pkg::S_IDLE; // [R12] [R27] [R3]
					else if (dec_exc != 8'h00) begin
						kind_r <= mb_pkg::K_EXC; // [R13]
						total_r <= `EXC_LEN; // [R15]
						st_r <= bc ? mb_pkg::S_IDLE : mb_pkg::S_SEND; // [R5]
					end else if (fn == `FN_WR1 || fn == `FN_WRN) begin
						wr_idx_r <= 16'h0000;
						ptr_r <= (fn == `FN_WR1) ? `P_DATA1 : `P_DATAN;
						ent_r <= (fn == `FN_WR1) ? 8'h01 : ent[7:0];
						st_r <= mb_pkg::S_WRITE;
					end else if (fn == `FN_LOOP) begin
						kind_r <= mb_pkg::K_ECHO; // [R7]
						total_r <= len_r - 16'h0002;
						st_r <= mb_pkg::S_SEND;
					end else begin
						kind_r <= mb_pkg::K_READ;
						total_r <= `RD_HDR + (nw << 1); // [R2]
						st_r <= mb_pkg::S_SEND;
					end
				end
				mb_pkg::S_WRITE: begin
					// a failing comms entry is skipped; later entries still go in
					if (tbl == `TBL_COMMS) begin
						if (wr_code != 8'h00) begin
							if (exc_r == 8'h00)
								exc_r <= wr_code; // [R17] [R18]
						end else if (wr_ent == `OFF_ACCESS)
							access_r <= wr_val[15:0]; // [R25]
						else if (wr_ent == `OFF_ADDR)
							slave_r <= wr_val[7:0];
						else
							baud_r <= wr_val[15:0];
					end else begin
						mem_wr_r <= 1'b1; // [R4] [R5]
						mem_addr_r <= {tbl, wr_ent}; // [R24]
						mem_wdata_r <= wr_val; // [R6]
					end
					ptr_r <= ptr_r + (wr_wide ? 16'h0004 : 16'h0002);
					wr_idx_r <= wr_idx_r + 16'h0001;
					if (wr_idx_r[7:0] == ent_r - 8'h01) begin
						// response only after the last entry is written
						kind_r <= (exc_r != 8'h00 || (tbl == `TBL_COMMS && wr_code != 8'h00)) ?
							mb_pkg::K_EXC : mb_pkg::K_ECHO;
						total_r <= (exc_r != 8'h00 || (tbl == `TBL_COMMS && wr_code != 8'h00)) ?
							`EXC_LEN : `HDR_LEN; // [R4] [R9]
						st_r <= bc ? mb_pkg::S_IDLE : mb_pkg::S_SEND; // [R5]
					end
				end
				mb_pkg::S_SEND: begin
					if (!tx_valid_r) begin
						if (need_fetch) begin
							mem_rd_r <= 1'b1;
							mem_addr_r <= {tbl, rd_ent}; // [R24]
							st_r <= mb_pkg::S_RDW;
						end else begin
							tx_data_r <= tx_byte;
							tx_valid_r <= 1'b1;
							if (idx_r < total_r)
								crc_tx_r <= crc_byte(crc_tx_r, tx_byte); // [R9] [R23]
						end
					end else if (tx_ready) begin
						tx_valid_r <= 1'b0;
						if (idx_r[0] ^ RD_HDR_W[0])
							word_ok_r <= 1'b0;
						idx_r <= idx_r + 16'h0001;
						if (idx_r > total_r)
							st_r <= mb_pkg::S_IDLE;
					end
				end
				mb_pkg::S_RDW: begin
					mem_rd_r <= 1'b0;
					st_r <= mb_pkg::S_RDC;
				end
				mb_pkg::S_RDC: begin
					// comms setup lives here, not in the meter tables
					if (tbl == `TBL_COMMS)
						word_r <= {16'h0000, (mem_addr_r[7:0] == `OFF_ACCESS) ? access_r :
							(mem_addr_r[7:0] == `OFF_ADDR) ? {8'h00, slave_r} : baud_r};
					else
						word_r <= mem_rdata;
					word_ok_r <= 1'b1;
					st_r <= mb_pkg::S_SEND;
				end
				default: st_r <= mb_pkg::S_IDLE;
			endcase
		end
	end

	// indicator stretchers: addressed, fault, line toggle
	logic [31:0] hold_r [3];
	logic [31:0] blink_r;
	logic [2:0] ind_evt;
	logic blink_on_r;
	assign ind_evt[0] = (st_r == mb_pkg::S_CHECK) && own; // [R19]
	assign ind_evt[1] = (st_r == mb_pkg::S_CHECK) && own && (!crc_ok || dec_exc != 8'h00); // [R20]
	assign ind_evt[2] = (rx_pin != rx_pin_r); // [R21]
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_pin_r <= 1'b1;
			for (int i = 0; i < 3; i++)
				hold_r[i] <= 32'h0;
		end else begin
			rx_pin_r <= rx_pin;
			for (int i = 0; i < 3; i++) begin
				if (ind_evt[i])
					hold_r[i] <= 32'(HOLD_CYCLES);
				else if (hold_r[i] != 32'h0)
					hold_r[i] <= hold_r[i] - 32'h1;
			end
		end
	end

	// late fault from a rejected comms write also lights the fault indicator
	logic fault_late_r;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			blink_r <= 32'h0;
			blink_on_r <= 1'b1;
			fault_late_r <= 1'b0;
		end else begin
			fault_late_r <= (st_r == mb_pkg::S_WRITE) && own && tbl == `TBL_COMMS && wr_code != 8'h00; // [R20]
			if (blink_r >= 32'(HOLD_CYCLES - 1)) begin
				blink_r <= 32'h0;
				blink_on_r <= !blink_on_r;
			end else
				blink_r <= blink_r + 32'h1;
		end
	end

	logic addr_ind_r, fault_ind_r, tog_ind_r, link_ind_r;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr_ind_r <= 1'b0;
			fault_ind_r <= 1'b0;
			tog_ind_r <= 1'b0;
			link_ind_r <= 1'b1;
		end else begin
			addr_ind_r <= ind_evt[0] || hold_r[0] != 32'h0;
			fault_ind_r <= ind_evt[1] || fault_late_r || hold_r[1] != 32'h0;
			tog_ind_r <= ind_evt[2] || hold_r[2] != 32'h0;
			link_ind_r <= !meter_busy || blink_on_r; // [R22]
		end
	end

	assign tx_data = tx_data_r;
	assign tx_valid = tx_valid_r;
	assign mem_addr = mem_addr_r;
	assign mem_rd = mem_rd_r;
	assign mem_wr = mem_wr_r;
	assign mem_wdata = mem_wdata_r;
	assign slave_addr = slave_r;
	assign baud_rate = baud_r;
	assign addr_frame_ind = addr_ind_r;
	assign fault_ind = fault_ind_r;
	assign line_toggle_indicator = tog_ind_r;
	assign meter_link_ind = link_ind_r;
endmodule // modbus_cmd

//--- core/mb_params.svh
`ifndef MB_PARAMS_SVH
`define MB_PARAMS_SVH
`define CLK_HZ 20000000
`define GAP_US 4010
`define HOLD_MS 100
`define CRC_INIT 16'hffff
`define CRC_POLY 16'ha001
`define FN_RD_HOLD 8'h03
`define FN_RD_IN 8'h04
`define FN_WR1 8'h06
`define FN_LOOP 8'h08
`define FN_WRN 8'h10
`define EXC_FLAG 8'h80
`define EXC_FUNC 8'h01
`define EXC_RANGE 8'h02
`define EXC_BIG 8'h03
`define EXC_SMALL 8'h04
`define EXC_VALUE 8'h05
`define EXC_LOCK 8'h06
`define BCAST 8'h00
`define REQ_LEN 16'h0008
`define WRN_LEN 16'h0009
`define MIN_LEN 16'h0004
`define RD_MAX 16'h007d
`define P_DATA1 16'h0004
`define P_DATAN 16'h0007
`define P_BCNT 6
`define HDR_LEN 16'h0006
`define EXC_LEN 16'h0003
`define RD_HDR 16'h0003
`define TBL_INST 8'h01
`define TBL_ENERGY 8'h02
`define TBL_SETUP 8'h03
`define TBL_DESC 8'h07
`define TBL_COMMS 8'h08
`define SZ_INST 8'h03
`define SZ_ENERGY 8'h05
`define SZ_SETUP 8'h06
`define SZ_DESC 8'h03
`define SZ_COMMS 8'h03
`define OFF_ACCESS 8'h00
`define OFF_ADDR 8'h01
`define OFF_BAUD 8'h02
`define UNLOCK_KEY 16'h007b
`define ACCESS_MAX 16'h00ff
`define ADDR_MAX 16'h00f7
`define BAUD_48 16'h0030
`define BAUD_96 16'h0060
`define BAUD_192 16'h00c0
`endif

//--- core/mb_pkg.sv
package mb_pkg;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_CHECK = 3'h1,
		S_WRITE = 3'h3,
		S_SEND = 3'h2,
		S_RDW = 3'h6,
		S_RDC = 3'h7
	} state_t;
	typedef enum logic [1:0] {K_ECHO = 2'h0, K_EXC = 2'h1, K_READ = 2'h2} kind_t;
endpackage

//--- testbench/mb_host.sv
`timescale 1ns/1ps
module mb_host (
	// clock
	input wire logic clk,
	// towards the device
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic rx_pin,
	// from the device
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	// pacing
	input wire logic slow
);
	logic [7:0] got[$];
	logic [1:0] pace_r;
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'h0;
		rx_pin = 1'h1;
		tx_ready = 1'h0;
		pace_r = 2'h0;
	end
	// four cycles a byte, far inside the idle gap
	task automatic put(input logic [7:0] b);
		@(posedge clk);
		rx_data <= b;
		rx_valid <= 1'h1;
		rx_pin <= ~rx_pin;
		@(posedge clk);
		rx_valid <= 1'h0;
		rx_data <= ~b;
		repeat (2) @(posedge clk);
	endtask
	// slow mode stalls three cycles in four
	always @(posedge clk) begin
		if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
		end
		pace_r <= pace_r + 2'h1;
		tx_ready <= !slow || pace_r == 2'h3;
	end
endmodule // mb_host

//--- testbench/mb_chk_assertions.sv
`timescale 1ns/1ps
module mb_chk #(
	parameter int GAP_CYCLES = 40
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// link
	input wire logic rx_valid,
	input wire logic rx_pin,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_ready,
	// tables and setup
	input wire logic [15:0] mem_addr,
	input wire logic mem_wr,
	input wire logic [31:0] mem_wdata,
	input wire logic [7:0] slave_addr,
	input wire logic [15:0] baud_rate,
	input wire logic line_toggle_indicator
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	int quiet_r;
	always_ff @(posedge clk) begin
		if (sys_rst || rx_valid) begin
			quiet_r <= 0;
		end else if (quiet_r < GAP_CYCLES) begin
			quiet_r <= quiet_r + 1;
		end
	end
	sequence s_tx_wait; tx_valid && !tx_ready; endsequence
	sequence s_tx_held; tx_valid && $stable(tx_data); endsequence
	property p_tx_hold; s_tx_wait |=> s_tx_held; endproperty
	property p_reply_gap; $rose(tx_valid) |-> quiet_r >= GAP_CYCLES - 1; endproperty
	property p_wr_table; mem_wr |-> mem_addr[15:8] inside {8'h02, 8'h03}; endproperty
	property p_wr_upper; mem_wr && mem_addr[15:8] == 8'h03 |-> mem_wdata[31:16] == 16'h0000; endproperty
	property p_wr_quiet; mem_wr |-> !tx_valid; endproperty
	property p_baud; $changed(baud_rate) |-> baud_rate inside {16'h0030, 16'h0060, 16'h00c0}; endproperty
	property p_addr; $changed(slave_addr) |-> slave_addr inside {[8'h01:8'hf7]}; endproperty
	property p_toggle; $changed(rx_pin) |-> ##[0:4] line_toggle_indicator; endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx byte moved before acceptance");
	a_reply_gap: assert property (p_reply_gap) else $error("reply before idle gap");
	a_wr_table: assert property (p_wr_table) else $error("write to read-only table");
	a_wr_upper: assert property (p_wr_upper) else $error("int write with upper bits set");
	a_wr_quiet: assert property (p_wr_quiet) else $error("write during reply");
	a_baud: assert property (p_baud) else $error("illegal baud value");
	a_addr: assert property (p_addr) else $error("illegal slave address");
	a_toggle: assert property (p_toggle) else $error("line activity not shown");
endmodule // mb_chk
bind modbus_cmd mb_chk #(.GAP_CYCLES(GAP_CYCLES)) mb_chk_inst (.clk(clk), .sys_rst(sys_rst),
	.rx_valid(rx_valid), .rx_pin(rx_pin), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .slave_addr(slave_addr),
	.baud_rate(baud_rate), .line_toggle_indicator(line_toggle_indicator));

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam int GAP = 40;
	localparam int HOLD = 20;
	logic clk, sys_rst, rx_valid, rx_pin, tx_valid, tx_ready, mem_rd, mem_wr, meter_busy, slow;
	logic [7:0] rx_data, tx_data, slave_addr;
	logic [15:0] mem_addr, baud_rate;
	logic [31:0] mem_wdata, mem_rdata;
	logic [47:0] wr_log;
	logic addr_frame_ind, fault_ind, line_toggle_indicator, meter_link_ind;
	logic [2:0] ind;
	int failures, checks;
	modbus_cmd #(.GAP_CYCLES(GAP), .HOLD_CYCLES(HOLD)) modbus_cmd_inst (.clk(clk), .sys_rst(sys_rst),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_pin(rx_pin), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .meter_busy(meter_busy), .slave_addr(slave_addr), .baud_rate(baud_rate),
		.addr_frame_ind(addr_frame_ind), .fault_ind(fault_ind),
		.line_toggle_indicator(line_toggle_indicator), .meter_link_ind(meter_link_ind));
	mb_host mb_host_inst (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_pin(rx_pin),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	// word follows its address; stale data inverts instead of holding
	always @(posedge clk) begin
		mem_rdata <= mem_rd ? {mem_addr, ~mem_addr} : ~mem_rdata;
		if (mem_wr) begin
			wr_log <= {mem_addr, mem_wdata};
		end
	end
	function automatic logic [15:0] crc16(input logic [127:0] d, input int n);
		logic [15:0] c;
		c = 16'hffff;
		for (int i = n - 1; i >= 0; i--) begin
			c = c ^ {8'h00, d[8*i +: 8]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction
	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// frames right-aligned; check bytes go low first, a bad one is inverted
	task automatic run(input logic [127:0] rq, input int nq, input logic [127:0] ex, input int ne,
		input logic bad);
		logic [15:0] c;
		int idle;
		c = crc16(rq, nq) ^ {16{bad}};
		rq = (rq << 16) | {c[7:0], c[15:8]};
		ind = 3'h0;
		mb_host_inst.got.delete();
		for (int i = nq + 1; i >= 0; i--) begin
			mb_host_inst.put(rq[8*i +: 8]);
			#1;
			ind |= {addr_frame_ind, fault_ind, line_toggle_indicator};
		end
		idle = 0;
		for (int t = 0; t < 800 && idle < GAP + 20; t++) begin
			@(posedge clk);
			#1;
			idle = tx_valid ? 0 : idle + 1;
			ind |= {addr_frame_ind, fault_ind, line_toggle_indicator};
		end
		c = crc16(ex, ne);
		ex = (ex << 16) | {c[7:0], c[15:8]};
		chk("reply length", ne ? ne + 2 : 0, mb_host_inst.got.size());
		for (int i = 0; i < mb_host_inst.got.size() && i < ne + 2; i++) begin
			chk("reply byte", ex[8*(ne+1-i) +: 8], mb_host_inst.got[i]);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		finish_test();
	end
	initial begin
		sys_rst = 1'h1;
		meter_busy = 1'h0;
		slow = 1'h0;
		failures = 0;
		checks = 0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'h0;
		@(posedge clk);
		#1;
		chk("reset state", {8'h01, 16'h0060, 3'h4}, {slave_addr, baud_rate, meter_link_ind, fault_ind, tx_valid});
		for (int f = 3; f < 5; f++) begin
			run({8'h01, 8'(f), 32'h01000002}, 6, {8'h01, 8'(f), 40'h04fefffefe}, 7, 1'h0);
			chk("indicators", 3'h5, ind);
		end
		@(posedge clk);
		slow <= 1'h1;
		run(48'h010402030002, 6, 56'h0104040203fdfc, 7, 1'h0);
		@(posedge clk);
		slow <= 1'h0;
		run(48'h010603010002, 6, 48'h010603010002, 6, 1'h0);
		chk("write", 48'h030100000002, wr_log);
		run(48'h01060201c350, 6, 48'h01060201c350, 6, 1'h0);
		chk("write", 48'h02010000c350, wr_log);
		run(88'h0110030000020400050001, 11, 48'h011003000002, 6, 1'h0);
		chk("write", 48'h030100000001, wr_log);
		run(88'h0110020300020412345678, 11, 48'h011002030002, 6, 1'h0);
		chk("write", 48'h020312345678, wr_log);
		run(88'h0110030000020600050001, 11, 24'h019003, 3, 1'h0);
		run(48'h0108000003e8, 6, 48'h0108000003e8, 6, 1'h0);
		run(48'h0108000103e8, 6, 24'h018801, 3, 1'h0);
		run(48'h010700000000, 6, 24'h018701, 3, 1'h0);
		chk("indicators", 3'h7, ind);
		run(48'h010409000001, 6, 24'h018402, 3, 1'h0);
		run(48'h01040100007e, 6, 24'h018403, 3, 1'h0);
		run(48'h010608020030, 6, 24'h018606, 3, 1'h0);
		chk("baud", 16'h0060, baud_rate);
		run(48'h01060800007b, 6, 48'h01060800007b, 6, 1'h0);
		run(48'h010608020032, 6, 24'h018605, 3, 1'h0);
		run(48'h0106080200c0, 6, 48'h0106080200c0, 6, 1'h0);
		chk("baud", 16'h00c0, baud_rate);
		run(48'h010608010000, 6, 24'h018604, 3, 1'h0);
		run(48'h0106080100f8, 6, 24'h018603, 3, 1'h0);
		chk("address", 8'h01, slave_addr);
		run(48'h010408000003, 6, 72'h010406007b000100c0, 9, 1'h0);
		run(48'h000603030007, 6, 0, 0, 1'h0);
		chk("write", 48'h030300000007, wr_log);
		run(48'h000401000001, 6, 0, 0, 1'h0);
		run(48'h0008000003e8, 6, 0, 0, 1'h0);
		run(72'h001003040001020002, 9, 0, 0, 1'h0);
		chk("write", 48'h030400000002, wr_log);
		run(48'h050603050009, 6, 0, 0, 1'h0);
		chk("indicators", 3'h1, ind);
		run(48'h010603050009, 6, 0, 0, 1'h1);
		chk("indicators", 3'h7, ind);
		chk("write", 48'h030400000002, wr_log);
		@(posedge clk);
		meter_busy <= 1'h1;
		ind = 3'h0;
		for (int t = 0; t < 4 * HOLD; t++) begin
			@(posedge clk);
			#1;
			ind[meter_link_ind] = 1'h1;
		end
		chk("link flashing", 3'h3, ind);
		@(posedge clk);
		meter_busy <= 1'h0;
		repeat (2 * HOLD + 4) @(posedge clk);
		#1;
		chk("link steady", 1'h1, meter_link_ind);
		finish_test();
	end
endmodule // tb_top
